// ### rtl/fpec_controller.sv
// Flash program/erase sequencer with lock, page scope and sector guard
// Behaviour
// - Reset leaves the controller locked; no program or erase until unlocked.
// - A user command or page write out of sequence locks the controller.
// - Unlock: 00H, page, 73H, 8CH, same page again.
// - Command 5EH maps sector guard over the page register address.
// - Any other command value maps the page register back.
// - User writes to the sector guard only set bits.
// - Sector guard clears to zero at every reset.
// - Write protect option blocks all user program and erase.
// - User byte program only inside the unlocked page; others ignored.
// - Programming only clears bits; erased bytes read FFH.
// - Processor stalled and interrupts held during program or erase.
// - Command 00H ends programming and locks.
// - User programming in a guarded sector leaves flash unchanged.
// - Command 95H after unlock erases the selected page.
// - Page erase sets every byte of the page to FFH.
// - Finished page erase releases the processor and locks.
// - User page erase only in unguarded sectors.
// - User code cannot mass erase.
// - Debugger ignores protection, page scope, and may clear guard bits.
// - Debugger skips second page write, may repage, may mass erase.
// - Only one page open at a time; new page needs new unlock.
// - Page register: 7-bit page is address 15..9; top bit maps info area.
// - Read-only state register at the command address.
`timescale 1ns/100ps
module fpec_controller (
    input  wire logic        ref_clk_in,
    input  wire logic        rstn_in,
    input  wire logic [11:0] reg_addr_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    input  wire logic [7:0]  reg_wdata_in,
    output logic [7:0]       reg_rdata_out,
    input  wire logic        dbg_access_in,
    input  wire logic        write_protect_opt_in,
    input  wire logic        mem_wr_in,
    input  wire logic [15:0] mem_addr_in,
    input  wire logic [7:0]  mem_wdata_in,
    input  wire logic [7:0]  flash_rdata_in,
    output logic [15:0]      flash_addr_out,
    output logic [7:0]       flash_wdata_out,
    output logic             flash_prog_out,
    output logic             flash_page_erase_out,
    output logic             flash_mass_erase_out,
    output logic             info_area_overlay_bit_out,
    output logic             cpu_stall_out,
    output logic             irq_hold_out
);
    import fpec_pkg::*;

    typedef struct packed {
        fpec_state_t state;
        logic [7:0]  page;
        logic        armed;
        logic [7:0]  guard;
        logic [15:0] khz;
        logic [7:0]  rdata;
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        prog;
        logic        erase;
        logic        mass;
        logic        stall;
        logic        start;
        logic [31:0] cycles;
    } fpec_ctl_t;

    localparam fpec_ctl_t FPEC_CTL_RESET = '{
        FPEC_LOCKED, FPEC_PAGE_RESET, 1'b0, FPEC_GUARD_RESET,
        FPEC_KHZ_RESET, 8'h00, 16'h0000, FPEC_ERASED_BYTE,
        1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 32'h0000_0001
    };

    fpec_ctl_t    st_ff;
    fpec_ctl_t    nxt_st;
    fpec_timer_if tmr ();

    logic cmd_wr;
    logic page_wr;
    logic busy;
    logic user_blocked;
    logic page_guarded;
    logic in_page;

    assign cmd_wr  = reg_wr_in && reg_addr_in == FPEC_ADDR_CMD;
    assign page_wr = reg_wr_in && reg_addr_in == FPEC_ADDR_PAGE;
    assign busy    = st_ff.state == FPEC_PROGRAM
                  || st_ff.state == FPEC_PAGE_ER
                  || st_ff.state == FPEC_MASS_ER;
    assign user_blocked = write_protect_opt_in && !dbg_access_in;
    assign page_guarded = st_ff.guard[fpec_sector(st_ff.page)]
                          && !dbg_access_in;
    assign in_page = dbg_access_in
                  || mem_addr_in[15:FPEC_ADDR_PAGE_LO]
                     == st_ff.page[FPEC_PAGE_MSB:0];

    always_comb begin
        nxt_st = st_ff;
        nxt_st.start = 1'b0;
        if (reg_rd_in) begin
            unique case (reg_addr_in)
                FPEC_ADDR_CMD:      nxt_st.rdata = {2'b00, st_ff.state};
                FPEC_ADDR_PAGE:     nxt_st.rdata = st_ff.state == FPEC_GUARD
                                    ? st_ff.guard : st_ff.page;
                FPEC_ADDR_KHZ_HIGH: nxt_st.rdata = st_ff.khz[15:8];
                FPEC_ADDR_KHZ_LOW:  nxt_st.rdata = st_ff.khz[7:0];
                default:            nxt_st.rdata = 8'h00;
            endcase
        end
        if (reg_wr_in && reg_addr_in == FPEC_ADDR_KHZ_HIGH) begin
            nxt_st.khz[15:8] = reg_wdata_in;
        end
        if (reg_wr_in && reg_addr_in == FPEC_ADDR_KHZ_LOW) begin
            nxt_st.khz[7:0] = reg_wdata_in;
        end
        if (busy) begin
            // Register and memory writes cannot arrive: the core is stalled
            if (tmr.done) begin
                nxt_st.prog  = 1'b0;
                nxt_st.erase = 1'b0;
                nxt_st.mass  = 1'b0;
                nxt_st.stall = 1'b0;
                nxt_st.state = st_ff.state == FPEC_PROGRAM
                               ? FPEC_OPEN : FPEC_LOCKED;
            end
        end else if (cmd_wr) begin
            nxt_st.armed = 1'b0;
            if (reg_wdata_in == FPEC_CMD_GUARD) begin
                nxt_st.state = FPEC_GUARD;
            end else begin
                // Anything else drops the guard mapping and locks by default
                nxt_st.state = FPEC_LOCKED;
                unique case (st_ff.state)
                    FPEC_LOCKED: begin
                        if (reg_wdata_in == FPEC_CMD_UNLOCK1 && st_ff.armed) begin
                            nxt_st.state = FPEC_FIRST;
                        end
                    end
                    FPEC_FIRST: begin
                        if (reg_wdata_in == FPEC_CMD_UNLOCK2) begin
                            nxt_st.state = dbg_access_in
                                           ? FPEC_OPEN : FPEC_SECOND;
                        end
                    end
                    FPEC_OPEN: begin
                        if (reg_wdata_in == FPEC_CMD_PAGE_ER
                            && !user_blocked && !page_guarded) begin
                            nxt_st.state  = FPEC_PAGE_ER;
                            nxt_st.erase  = 1'b1;
                            nxt_st.stall  = 1'b1;
                            nxt_st.start  = 1'b1;
                            nxt_st.addr   = {st_ff.page[FPEC_PAGE_MSB:0],
                                             9'h000};
                            nxt_st.cycles = fpec_cycles(st_ff.khz,
                                FPEC_PAGE_ER_MS, FPEC_MS_PER_MS);
                        end else if (reg_wdata_in == FPEC_CMD_MASS_ER
                                     && dbg_access_in) begin
                            nxt_st.state  = FPEC_MASS_ER;
                            nxt_st.mass   = 1'b1;
                            nxt_st.stall  = 1'b1;
                            nxt_st.start  = 1'b1;
                            nxt_st.addr   = 16'h0000;
                            nxt_st.cycles = fpec_cycles(st_ff.khz,
                                FPEC_MASS_ER_MS, FPEC_MS_PER_MS);
                        end
                    end
                    default: begin
                        nxt_st.state = FPEC_LOCKED;
                    end
                endcase
            end
        end else if (page_wr) begin
            if (st_ff.state == FPEC_GUARD) begin
                nxt_st.guard = dbg_access_in ? reg_wdata_in
                               : st_ff.guard | reg_wdata_in;
            end else begin
                nxt_st.page  = reg_wdata_in;
                nxt_st.state = FPEC_LOCKED;
                unique case (st_ff.state)
                    FPEC_LOCKED: begin
                        nxt_st.armed = 1'b1;
                    end
                    FPEC_SECOND: begin
                        if (dbg_access_in || reg_wdata_in == st_ff.page) begin
                            nxt_st.state = FPEC_OPEN;
                        end
                    end
                    FPEC_OPEN: begin
                        if (dbg_access_in) begin
                            nxt_st.state = FPEC_OPEN;
                        end
                    end
                    default: begin
                        nxt_st.state = FPEC_LOCKED;
                    end
                endcase
            end
        end else if (mem_wr_in && st_ff.state == FPEC_OPEN) begin
            // Misses are dropped silently and the page stays open
            if (in_page && !user_blocked && !page_guarded) begin
                nxt_st.state  = FPEC_PROGRAM;
                nxt_st.prog   = 1'b1;
                nxt_st.stall  = 1'b1;
                nxt_st.start  = 1'b1;
                nxt_st.addr   = mem_addr_in;
                nxt_st.wdata  = mem_wdata_in & flash_rdata_in;
                nxt_st.cycles = fpec_cycles(st_ff.khz,
                    FPEC_PROG_TIME_US, FPEC_US_PER_MS);
            end
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            st_ff <= FPEC_CTL_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign tmr.start  = st_ff.start;
    assign tmr.cycles = st_ff.cycles;

    fpec_pulse_timer u_timer (
        .ref_clk_in (ref_clk_in),
        .rstn_in    (rstn_in),
        .tmr        (tmr)
    );

    assign reg_rdata_out             = st_ff.rdata;
    assign flash_addr_out            = st_ff.addr;
    assign flash_wdata_out           = st_ff.wdata;
    assign flash_prog_out            = st_ff.prog;
    assign flash_page_erase_out      = st_ff.erase;
    assign flash_mass_erase_out      = st_ff.mass;
    assign info_area_overlay_bit_out = st_ff.page[FPEC_INFO_BIT];
    assign cpu_stall_out             = st_ff.stall;
    assign irq_hold_out              = st_ff.stall;

    a_reset_locks: assert property (@(posedge ref_clk_in)
        !rstn_in |=> st_ff.state == FPEC_LOCKED && st_ff.guard == 8'h00)
        else $error("Controller not locked with clear guard after reset");

    a_unlock_seq: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        st_ff.state == FPEC_SECOND && page_wr && !dbg_access_in
        && reg_wdata_in != st_ff.page |=> st_ff.state == FPEC_LOCKED)
        else $error("Mismatched second page write did not lock");

    a_guard_map: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        st_ff.state == FPEC_GUARD && reg_rd_in
        && reg_addr_in == FPEC_ADDR_PAGE
        |=> reg_rdata_out == $past(st_ff.guard))
        else $error("Guard register not mapped after select command");

    a_guard_set_only: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        !dbg_access_in |=> (st_ff.guard & $past(st_ff.guard))
        == $past(st_ff.guard))
        else $error("User write cleared a sector guard bit");

    a_blocked_erase: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        st_ff.state == FPEC_OPEN && cmd_wr && reg_wdata_in == FPEC_CMD_PAGE_ER
        && (user_blocked || page_guarded) |=> !flash_page_erase_out
        && st_ff.state == FPEC_LOCKED)
        else $error("Protected page erase was started");

    a_page_scope: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        st_ff.state == FPEC_OPEN && mem_wr_in && !cmd_wr && !page_wr
        && !in_page |=> !flash_prog_out ##1 !flash_prog_out)
        else $error("Byte outside open page was programmed");

    a_clear_only: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        $rose(flash_prog_out) |-> (flash_wdata_out & ~$past(flash_rdata_in))
        == 8'h00)
        else $error("Programming would set a bit to one");

    a_stall_busy: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        busy |-> cpu_stall_out && irq_hold_out)
        else $error("Processor not stalled during operation");

    a_zero_locks: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        !busy && cmd_wr && reg_wdata_in == FPEC_CMD_RESET
        |=> st_ff.state == FPEC_LOCKED ##1 !flash_prog_out)
        else $error("Command 00H did not lock the controller");

    a_erase_relock: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        st_ff.state == FPEC_PAGE_ER && tmr.done |=> st_ff.state == FPEC_LOCKED
        && !cpu_stall_out && !flash_page_erase_out)
        else $error("Erase end did not release and lock");

    a_no_user_mass: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        !dbg_access_in && cmd_wr && reg_wdata_in == FPEC_CMD_MASS_ER
        |=> !flash_mass_erase_out)
        else $error("User code started a mass erase");
endmodule

// ### rtl/fpec_pkg.sv
// Shared constants, types and helpers of the flash program/erase controller
package fpec_pkg;

    // Register file addresses
    localparam logic [11:0] FPEC_ADDR_CMD      = 12'hff8;
    localparam logic [11:0] FPEC_ADDR_PAGE     = 12'hff9;
    localparam logic [11:0] FPEC_ADDR_KHZ_HIGH = 12'hffa;
    localparam logic [11:0] FPEC_ADDR_KHZ_LOW  = 12'hffb;

    // Values of command_code_field
    localparam logic [7:0] FPEC_CMD_RESET   = 8'h00;
    localparam logic [7:0] FPEC_CMD_UNLOCK1 = 8'h73;
    localparam logic [7:0] FPEC_CMD_UNLOCK2 = 8'h8c;
    localparam logic [7:0] FPEC_CMD_PAGE_ER = 8'h95;
    localparam logic [7:0] FPEC_CMD_MASS_ER = 8'h63;
    localparam logic [7:0] FPEC_CMD_GUARD   = 8'h5e;

    // Field positions
    localparam int FPEC_INFO_BIT     = 7;
    localparam int FPEC_PAGE_MSB     = 6;
    localparam int FPEC_ADDR_PAGE_LO = 9;
    localparam int FPEC_SECTOR_LO    = 4;

    // Values after reset
    localparam logic [7:0]  FPEC_PAGE_RESET  = 8'h00;
    localparam logic [7:0]  FPEC_GUARD_RESET = 8'h00;
    localparam logic [15:0] FPEC_KHZ_RESET   = 16'h0000;
    localparam logic [7:0]  FPEC_ERASED_BYTE = 8'hff;

    // Pulse lengths, scaled by clock_khz_value at run time
    localparam logic [15:0] FPEC_PROG_TIME_US  = 16'h0028;
    localparam logic [15:0] FPEC_PAGE_ER_MS    = 16'h000a;
    localparam logic [15:0] FPEC_MASS_ER_MS    = 16'h00c8;
    localparam logic [15:0] FPEC_US_PER_MS     = 16'h03e8;
    localparam logic [15:0] FPEC_MS_PER_MS     = 16'h0001;

    // Values of flash_state_register, also the controller states
    typedef enum logic [5:0] {
        FPEC_LOCKED  = 6'b00_0000,
        FPEC_FIRST   = 6'b00_0001,
        FPEC_SECOND  = 6'b00_0010,
        FPEC_OPEN    = 6'b00_0011,
        FPEC_GUARD   = 6'b00_0100,
        FPEC_PROGRAM = 6'b00_1000,
        FPEC_PAGE_ER = 6'b01_0000,
        FPEC_MASS_ER = 6'b10_0000
    } fpec_state_t;

    // Cycles for a pulse: khz * time / divisor, rounded up, at least one
    function automatic logic [31:0] fpec_cycles(
        input logic [15:0] khz,
        input logic [15:0] time_val,
        input logic [15:0] divisor
    );
        logic [31:0] prod;
        prod = 32'(khz) * 32'(time_val);
        prod = (prod + 32'(divisor) - 32'h0000_0001) / 32'(divisor);
        if (prod == 32'h0000_0000) begin
            prod = 32'h0000_0001;
        end
        return prod;
    endfunction

    // Sector that holds a page
    function automatic logic [2:0] fpec_sector(input logic [7:0] page);
        return page[FPEC_PAGE_MSB:FPEC_SECTOR_LO];
    endfunction

endpackage

// ### rtl/fpec_timer_if.sv
// Link between the sequencer and its pulse timer
`timescale 1ns/100ps
interface fpec_timer_if;
    logic        start;
    logic [31:0] cycles;
    logic        done;

    modport ctrl  (output start, output cycles, input done);
    modport timer (input start, input cycles, output done);
endinterface

// ### rtl/fpec_pulse_timer.sv
// Down counter that times one program or erase pulse
`timescale 1ns/100ps
module fpec_pulse_timer (
    input  wire logic   ref_clk_in,
    input  wire logic   rstn_in,
    fpec_timer_if.timer tmr
);
    import fpec_pkg::*;

    typedef struct packed {
        logic        run;
        logic [31:0] left;
        logic        done;
    } fpec_tmr_t;

    localparam fpec_tmr_t FPEC_TMR_RESET = '{1'b0, 32'h0000_0000, 1'b0};

    fpec_tmr_t st_ff;
    fpec_tmr_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.done = 1'b0;
        if (tmr.start) begin
            nxt_st.run = 1'b1;
            nxt_st.left = tmr.cycles;
        end else if (st_ff.run) begin
            if (st_ff.left <= 32'h0000_0001) begin
                nxt_st.run = 1'b0;
                nxt_st.done = 1'b1;
            end else begin
                nxt_st.left = st_ff.left - 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            st_ff <= FPEC_TMR_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign tmr.done = st_ff.done;

    a_timer_length: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        tmr.start && tmr.cycles == 32'h0000_0001
        |=> !tmr.done ##1 tmr.done)
        else $error("Pulse timer did not end after the loaded count");
endmodule

// ### testbench/fpec_flash_model.sv
// Behavioural flash array on the far side of the controller
`timescale 1ns/100ps
module fpec_flash_model (
    input  wire logic        ref_clk_in,
    input  wire logic [15:0] rd_addr_in,
    output logic [7:0]       rd_data_out,
    input  wire logic [15:0] addr_in,
    input  wire logic [7:0]  wdata_in,
    input  wire logic        prog_in,
    input  wire logic        page_er_in,
    input  wire logic        mass_er_in
);
    logic [7:0]  mem [0:65535];
    logic [15:0] held;
    logic [7:0]  held_d;
    logic        prog_d = 1'b0;
    logic        page_d = 1'b0;
    logic        mass_d = 1'b0;

    initial begin
        for (int i = 0; i < 65536; i++)
            mem[i] = 8'hff;
    end

    assign rd_data_out = mem[rd_addr_in];

    always @(posedge ref_clk_in) begin
        prog_d <= prog_in;
        page_d <= page_er_in;
        mass_d <= mass_er_in;
        if (prog_in && !prog_d) begin
            held   <= addr_in;
            held_d <= wdata_in;
        end
        if (page_er_in && !page_d)
            held <= addr_in;
        // Cells change only as the pulse ends, so a short pulse is seen
        if (!prog_in && prog_d)
            mem[held] <= mem[held] & held_d;
        if (!page_er_in && page_d)
            for (int j = 0; j < 512; j++)
                mem[{held[15:9], j[8:0]}] <= 8'hff;
        if (!mass_er_in && mass_d)
            for (int j = 0; j < 65536; j++)
                mem[j] <= 8'hff;
    end
endmodule

// ### testbench/fpec_controller_test.sv
// Self-checking bench of the flash program/erase controller
`timescale 1ns/100ps
module fpec_controller_test;
    import fpec_pkg::*;
    logic        clk, rstn, rw, rr, dbg, wp, mw;
    logic [11:0] ra;
    logic [7:0]  wd, rdat, md, frd, fwd;
    logic [15:0] ma, fa;
    logic        fp, fpe, fme, info, stall, hold;
    logic [31:0] seed = 32'h0001_5cde;
    logic [7:0]  exp_mem [logic [15:0]];
    int          num_errors = 0;
    int          num_checks = 0;

    fpec_controller u_fpec_controller (
        .ref_clk_in(clk), .rstn_in(rstn), .reg_addr_in(ra),
        .reg_wr_in(rw), .reg_rd_in(rr), .reg_wdata_in(wd),
        .reg_rdata_out(rdat), .dbg_access_in(dbg),
        .write_protect_opt_in(wp), .mem_wr_in(mw), .mem_addr_in(ma),
        .mem_wdata_in(md), .flash_rdata_in(frd), .flash_addr_out(fa),
        .flash_wdata_out(fwd), .flash_prog_out(fp),
        .flash_page_erase_out(fpe), .flash_mass_erase_out(fme),
        .info_area_overlay_bit_out(info), .cpu_stall_out(stall),
        .irq_hold_out(hold)
    );
    fpec_flash_model u_fpec_flash_model (
        .ref_clk_in(clk), .rd_addr_in(ma), .rd_data_out(frd),
        .addr_in(fa), .wdata_in(fwd), .prog_in(fp), .page_er_in(fpe),
        .mass_er_in(fme)
    );

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction

    function automatic logic [7:0] ev(logic [15:0] a);
        return exp_mem.exists(a) ? exp_mem[a] : 8'hff;
    endfunction

    task automatic close_out();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic do_reset();
        @(negedge clk);
        rstn = 1'b0;
        repeat (8) @(negedge clk);
        rstn = 1'b1;
    endtask

    task automatic wr(logic [11:0] a, logic [7:0] d);
        @(negedge clk);
        ra = a;
        wd = d;
        rw = 1'b1;
        @(negedge clk);
        rw = 1'b0;
    endtask

    task automatic rd(logic [11:0] a, logic [7:0] exp, string what);
        @(negedge clk);
        ra = a;
        rr = 1'b1;
        @(negedge clk);
        rr = 1'b0;
        chk(what, rdat, exp);
    endtask

    task automatic st(logic [7:0] exp);
        rd(FPEC_ADDR_CMD, exp, "status");
    endtask

    task automatic cmpmem();
        foreach (exp_mem[k])
            chk("flash", u_fpec_flash_model.mem[k], exp_mem[k]);
    endtask

    task automatic wipe(logic [7:0] pg, bit all);
        foreach (exp_mem[k])
            if (all || k[15:9] == pg[6:0])
                exp_mem[k] = 8'hff;
    endtask

    // Bounded wait; a stuck stall would freeze the core forever
    task automatic waitidle();
        int n;
        n = 0;
        while (stall !== 1'b0 && n < 20000) begin
            @(negedge clk);
            n++;
        end
        if (n == 20000) begin
            num_errors++;
            close_out();
        end
    endtask

    task automatic unlock(logic [7:0] pg, bit dm);
        dbg = dm;
        wr(FPEC_ADDR_CMD, FPEC_CMD_RESET);
        wr(FPEC_ADDR_PAGE, pg);
        wr(FPEC_ADDR_CMD, FPEC_CMD_UNLOCK1);
        st(8'h01);
        wr(FPEC_ADDR_CMD, FPEC_CMD_UNLOCK2);
        st(dm ? 8'h03 : 8'h02);
        if (!dm)
            wr(FPEC_ADDR_PAGE, pg);
        st(8'h03);
    endtask

    task automatic prog(logic [15:0] a, bit ok);
        logic [7:0] d;
        d = rnd();
        @(negedge clk);
        ma = a;
        md = d;
        mw = 1'b1;
        @(negedge clk);
        mw = 1'b0;
        chk("stall", {7'h00, stall}, {7'h00, ok});
        if (ok)
            exp_mem[a] = ev(a) & d;
        waitidle();
        // Array cells commit one edge after the pulse ends
        @(negedge clk);
        cmpmem();
    endtask

    task automatic erase(logic [7:0] cv, bit ok);
        wr(FPEC_ADDR_CMD, cv);
        @(negedge clk);
        chk("hold", {7'h00, hold}, {7'h00, ok});
        waitidle();
        st(8'h00);
    endtask

    initial begin
        rstn = 1'b0;
        ra = 12'h000;
        wd = 8'h00;
        rw = 1'b0;
        rr = 1'b0;
        dbg = 1'b0;
        wp = 1'b0;
        mw = 1'b0;
        ma = 16'h0000;
        md = 8'h00;
        do_reset();
        prog(16'h0000, 1'b0);
        st(8'h00);
        rd(FPEC_ADDR_PAGE, 8'h00, "page");
        wr(FPEC_ADDR_CMD, FPEC_CMD_RESET);
        wr(FPEC_ADDR_PAGE, 8'h85);
        chk("info", {7'h00, info}, 8'h01);
        wr(FPEC_ADDR_CMD, FPEC_CMD_GUARD);
        st(8'h04);
        rd(FPEC_ADDR_PAGE, 8'h00, "guard");
        wr(FPEC_ADDR_PAGE, 8'h02);
        wr(FPEC_ADDR_PAGE, 8'h00);
        rd(FPEC_ADDR_PAGE, 8'h02, "guard");
        wr(FPEC_ADDR_CMD, FPEC_CMD_RESET);
        st(8'h00);
        rd(FPEC_ADDR_PAGE, 8'h85, "page");
        wr(FPEC_ADDR_KHZ_HIGH, 8'h00);
        wr(FPEC_ADDR_KHZ_LOW, 8'h01);
        rd(FPEC_ADDR_KHZ_LOW, 8'h01, "khz");
        $display("test reset_and_guard done");
        unlock(8'h05, 1'b0);
        for (int i = 0; i < 3; i++) begin
            logic [15:0] pa;
            pa = {7'h05, 1'b0, rnd()};
            // Distinct bytes, so none is programmed more than twice
            pa[8:7] = 2'(i);
            prog(pa, 1'b1);
            prog(pa, 1'b1);
        end
        prog({7'h06, 1'b1, rnd()}, 1'b0);
        wp = 1'b1;
        prog({7'h05, 1'b1, rnd()}, 1'b0);
        wp = 1'b0;
        st(8'h03);
        wr(FPEC_ADDR_PAGE, 8'h06);
        st(8'h00);
        prog({7'h05, 1'b1, rnd()}, 1'b0);
        $display("test user_program done");
        wr(FPEC_ADDR_CMD, FPEC_CMD_RESET);
        wr(FPEC_ADDR_PAGE, 8'h05);
        wr(FPEC_ADDR_CMD, FPEC_CMD_UNLOCK1);
        wr(FPEC_ADDR_PAGE, 8'h05);
        st(8'h00);
        unlock(8'h05, 1'b0);
        wr(FPEC_ADDR_CMD, 8'h55);
        st(8'h00);
        wr(FPEC_ADDR_PAGE, 8'h05);
        wr(FPEC_ADDR_CMD, FPEC_CMD_UNLOCK1);
        wr(FPEC_ADDR_CMD, FPEC_CMD_UNLOCK2);
        wr(FPEC_ADDR_PAGE, 8'h07);
        st(8'h00);
        unlock(8'h05, 1'b0);
        erase(FPEC_CMD_MASS_ER, 1'b0);
        cmpmem();
        $display("test out_of_sequence done");
        wp = 1'b1;
        unlock(8'h12, 1'b1);
        prog({7'h12, 1'b0, rnd()}, 1'b1);
        prog({7'h30, 1'b0, rnd()}, 1'b1);
        wr(FPEC_ADDR_PAGE, 8'h13);
        st(8'h03);
        wp = 1'b0;
        unlock(8'h12, 1'b0);
        prog({7'h12, 1'b1, rnd()}, 1'b0);
        erase(FPEC_CMD_PAGE_ER, 1'b0);
        cmpmem();
        unlock(8'h05, 1'b0);
        erase(FPEC_CMD_PAGE_ER, 1'b1);
        wipe(8'h05, 1'b0);
        cmpmem();
        $display("test debug_and_erase done");
        do_reset();
        wr(FPEC_ADDR_CMD, FPEC_CMD_GUARD);
        rd(FPEC_ADDR_PAGE, 8'h00, "guard");
        wr(FPEC_ADDR_PAGE, 8'h02);
        dbg = 1'b1;
        wr(FPEC_ADDR_PAGE, 8'h00);
        rd(FPEC_ADDR_PAGE, 8'h00, "guard");
        wr(FPEC_ADDR_KHZ_LOW, 8'h01);
        unlock(8'h00, 1'b1);
        erase(FPEC_CMD_MASS_ER, 1'b1);
        wipe(8'h00, 1'b1);
        cmpmem();
        $display("test mass_erase done");
        close_out();
    end
endmodule
